// *** logic/ltsf_status_top.sv ***
// Purpose: status flag bank of a lin master / uart unit, AXI4-Lite slave
// Assumes: frame engine signals share REF_CLK and need no synchroniser
// Notes:   registers are 16 bits in the low half of each word
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
// Function
// R01: tx request write sets the tx status flag, bit 15.
// R02: automatic frame start in lin master mode also sets tx status.
// R03: uart through mode never sets tx status, tx empty or rx full.
// R04: tx status clears on unit disable or tx process completion.
// R05: rx request sets rx status, bit 14; clears on disable or rx done.
// R06: rx status and rx overflow never set in through or lin master mode.
// R07: tx empty, bit 13, set when last tx data sent; disable or w1c clears.
// R08: rx full, bit 12, set when last rx data stored; disable or w1c clears.
// R09: overflow discards new data and sets bit 11; disable or w1c clears.
// R10: received checksum mismatch sets checksum error, bit 10.
// R11: checksum error only in lin master with auto checksum; clears as others.
// R12: compare equal to scheduler count sets bit 9 and status interrupt.
// R13: scheduler flag only in lin master, scheduler on, auto start off.
// R14: status register is read-only at 8C hex, reset value 0000 hex.
// R15: state field reads 0 idle, 19 hex no response, else abnormal.
// R16: clearing unit enable halts and resets the unit and all flags.
// R17: software clears flags by writing ones before a transmission.
// R18: hardware set wins over a coincident software clear.
module ltsf_status_top
	import ltsf_pkg::*;
(
	input  wire logic              REF_CLK,
	input  wire logic              RST_N,
	input  wire logic              CE,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	input  wire logic              TX_LAST_SENT,
	input  wire logic              TX_DONE,
	input  wire logic              AUTO_FRAME_START,
	input  wire logic              RX_LAST_STORED,
	input  wire logic              RX_DONE,
	input  wire logic              RX_FRAME_START,
	input  wire logic              RX_BYTE_VALID,
	input  wire logic [7:0]        RX_BYTE,
	input  wire logic              RX_CHK_VALID,
	input  wire logic [7:0]        RX_CHK_BYTE,
	input  wire logic [2:0]        FRAME_ERR_SET,
	input  wire logic [SSL_W-1:0]  MASTER_STATE,
	output logic                   UNIT_ENABLE,
	output logic                   TX_REQ,
	output logic                   RX_REQ,
	output logic                   STATUS_INT_REQ,
	output logic                   IRQ
);
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == OFF_CTL_LOW) || (a == OFF_CTL_HIGH) ||
			(a == OFF_STAT_HIGH) || (a == OFF_STAT_CLR) ||
			(a == OFF_REQ) || (a == OFF_CMP) ||
			(a == OFF_IRQ_MASK) || (a == OFF_RX_DATA);
	endfunction

	function automatic logic [15:0] merge(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [3:0]  strb
	);
		logic [15:0] m;
		m     = {{8{strb[1]}}, {8{strb[0]}}};
		merge = (old_v & ~m) | (new_v & m);
	endfunction

	logic              aw_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic              w_held_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;
	logic [15:0]       ctl_low_reg;
	logic [15:0]       ctl_high_reg;
	logic [15:0]       cmp_reg;
	logic [15:0]       mask_reg;
	logic [15:0]       sched_cnt_reg;
	logic [7:0]        rx_data_reg;
	logic              rx_held_reg;
	logic [SSL_W-1:0]  ssl_reg;
	logic              tx_req_reg;
	logic              rx_req_reg;
	logic              int_req_reg;
	logic              irq_reg;

	// write path: address and data are taken in either order
	wire        do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	wire [15:0] wbits    = merge(16'h0000, w_data_reg[15:0], w_strb_reg);
	wire        wr_ctl_l = do_write && (aw_addr_reg == OFF_CTL_LOW);
	wire        wr_ctl_h = do_write && (aw_addr_reg == OFF_CTL_HIGH);
	wire        wr_clr   = do_write && (aw_addr_reg == OFF_STAT_CLR);
	wire        wr_req   = do_write && (aw_addr_reg == OFF_REQ);
	wire        wr_cmp   = do_write && (aw_addr_reg == OFF_CMP);
	wire        wr_mask  = do_write && (aw_addr_reg == OFF_IRQ_MASK);
	wire        rd_take  = S_AXI_ARVALID && !rvalid_reg;

	// configuration decode
	wire [1:0] mode    = ctl_low_reg[MODE_LSB +: 2];
	wire       unit_en = ctl_high_reg[BIT_PW];
	wire       through = (mode == MODE_UART_THRU);
	wire       lin_m   = (mode == MODE_LIN_MASTER);
	wire       uart    = !through && !lin_m;
	wire       afe     = ctl_low_reg[BIT_AFE];
	wire       acse    = ctl_low_reg[BIT_ACSE];
	wire       sche    = ctl_low_reg[BIT_SCHE];
	wire       trq     = wr_req && wbits[BIT_TRQ];
	wire       rrq     = wr_req && wbits[BIT_RRQ];

	// R13: scheduler gating
	wire sched_run   = unit_en && lin_m && sche && !afe;
	// R12: compare hit
	wire sched_match = sched_run && (sched_cnt_reg == cmp_reg);
	// R09: a byte arriving while one is held is dropped
	wire rx_ovf      = RX_BYTE_VALID && rx_held_reg;
	wire rx_store    = RX_BYTE_VALID && !rx_held_reg;
	wire rx_take     = rd_take && (S_AXI_ARADDR == OFF_RX_DATA);
	wire csum_err;

	logic [15:0] set_vec;
	logic [15:0] clr_vec;
	logic [FLAG_W-1:0] flags;
	wire  [15:0] status = {flags, ssl_reg};

	always_comb begin
		set_vec = 16'h0000;
		// R01: tx request; R02: automatic frame start; R03: not in through
		set_vec[BIT_SST]  = !through && (trq || (lin_m && afe && AUTO_FRAME_START));
		// R05: rx request; R06: only outside through and lin master
		set_vec[BIT_SSR]  = uart && rrq;
		// R07: tx buffer drained; R03: not in through
		set_vec[BIT_TXEF] = !through && TX_LAST_SENT;
		// R08: rx buffer filled; R03: not in through
		set_vec[BIT_RXFF] = !through && RX_LAST_STORED;
		// R06: overflow flag only in plain uart
		set_vec[BIT_ROVE] = uart && rx_ovf;
		// R11: checksum error qualified by mode and auto checksum
		set_vec[BIT_FCSE] = lin_m && acse && csum_err;
		set_vec[BIT_SRF]  = sched_match;
		set_vec[BIT_SFE +: 3] = lin_m ? FRAME_ERR_SET : 3'h0;
	end

	always_comb begin
		// R07: write-one-to-clear on the software clearable flags
		clr_vec = wr_clr ? (wbits & SW_CLR_MASK) : 16'h0000;
		// R04: tx completion clears tx status
		clr_vec[BIT_SST] = TX_DONE;
		// R05: rx completion clears rx status
		clr_vec[BIT_SSR] = RX_DONE;
	end

	// R16: flags held at zero while the unit is off
	// R18: set beats clear inside the flag bank
	ltsf_flags #(
		.W   (FLAG_W),
		.RST (STAT_HIGH_RST[15:FLAG_LSB])
	) u_flags (
		.clk    (REF_CLK),
		.rst_n  (RST_N),
		.ce     (CE),
		.en     (unit_en),
		.set_in (set_vec[15:FLAG_LSB]),
		.clr_in (clr_vec[15:FLAG_LSB]),
		.q      (flags)
	);

	// R10: checksum over received data against the received checksum
	ltsf_csum u_csum (
		.clk        (REF_CLK),
		.rst_n      (RST_N),
		.ce         (CE),
		.en         (unit_en),
		.start      (RX_FRAME_START),
		.byte_valid (RX_BYTE_VALID),
		.byte_in    (RX_BYTE),
		.chk_valid  (RX_CHK_VALID),
		.chk_in     (RX_CHK_BYTE),
		.err        (csum_err)
	);

	// R14: read mux, status is read-only and zero-extended
	wire [15:0] rd_word =
		(S_AXI_ARADDR == OFF_CTL_LOW)   ? ctl_low_reg :
		(S_AXI_ARADDR == OFF_CTL_HIGH)  ? ctl_high_reg :
		(S_AXI_ARADDR == OFF_STAT_HIGH) ? status :
		(S_AXI_ARADDR == OFF_CMP)       ? cmp_reg :
		(S_AXI_ARADDR == OFF_IRQ_MASK)  ? mask_reg :
		(S_AXI_ARADDR == OFF_RX_DATA)   ? {8'h00, rx_data_reg} : 16'h0000;

	assign S_AXI_AWREADY  = !aw_held_reg;
	assign S_AXI_WREADY   = !w_held_reg;
	assign S_AXI_BVALID   = bvalid_reg;
	assign S_AXI_BRESP    = bresp_reg;
	assign S_AXI_ARREADY  = !rvalid_reg;
	assign S_AXI_RVALID   = rvalid_reg;
	assign S_AXI_RDATA    = rdata_reg;
	assign S_AXI_RRESP    = rresp_reg;
	assign UNIT_ENABLE    = unit_en;
	assign TX_REQ         = tx_req_reg;
	assign RX_REQ         = rx_req_reg;
	assign STATUS_INT_REQ = int_req_reg;
	assign IRQ            = irq_reg;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end else if (CE) begin
			if (S_AXI_AWVALID && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (S_AXI_WVALID && !w_held_reg) begin
				w_held_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= RESP_OKAY;
		end else if (CE) begin
			if (rd_take) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= {16'h0000, rd_word};
				rresp_reg  <= is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			ctl_low_reg  <= CTL_RST;
			ctl_high_reg <= CTL_RST;
			cmp_reg      <= CMP_RST;
			mask_reg     <= MASK_RST;
		end else if (CE) begin
			if (wr_ctl_l) ctl_low_reg <= merge(ctl_low_reg, w_data_reg[15:0], w_strb_reg);
			if (wr_ctl_h) ctl_high_reg <= merge(ctl_high_reg, w_data_reg[15:0], w_strb_reg);
			if (wr_cmp) cmp_reg <= merge(cmp_reg, w_data_reg[15:0], w_strb_reg);
			if (wr_mask) mask_reg <= merge(mask_reg, w_data_reg[15:0], w_strb_reg);
		end
	end

	// R16: a disabled unit clears its counter, rx holding and state
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			sched_cnt_reg <= 16'h0000;
			rx_data_reg   <= 8'h00;
			rx_held_reg   <= 1'b0;
			ssl_reg       <= SSL_IDLE;
		end else if (CE) begin
			// R12: counter restarts on a hit so the period equals compare+1
			sched_cnt_reg <= (!sched_run || sched_match) ? 16'h0000 : sched_cnt_reg + 16'h0001;
			// R09: store only into an empty holding register
			if (unit_en && rx_store) rx_data_reg <= RX_BYTE;
			rx_held_reg <= unit_en && (rx_store || (rx_held_reg && !rx_take));
			// R15: state code is the engine state, idle when off
			ssl_reg <= unit_en ? MASTER_STATE : SSL_IDLE;
		end
	end

	// irq is registered, so it trails the flag by one cycle
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			tx_req_reg  <= 1'b0;
			rx_req_reg  <= 1'b0;
			int_req_reg <= 1'b0;
			irq_reg     <= 1'b0;
		end else if (CE) begin
			tx_req_reg  <= unit_en && trq;
			rx_req_reg  <= unit_en && rrq;
			// R12: status interrupt request with the scheduler event
			int_req_reg <= sched_match;
			irq_reg     <= |(status[15:FLAG_LSB] & mask_reg[15:FLAG_LSB]);
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_sched_hit;
		CE && sched_match;
	endsequence
	sequence s_sched_seen;
		status[BIT_SRF] && STATUS_INT_REQ;
	endsequence

	chk_tx_req_set: assert property ( // R01
		(CE && unit_en && !through && trq) |=> status[BIT_SST])
		else $error("tx request did not set tx status");
	chk_through_quiet: assert property ( // R03
		(CE && through && status[15:12] == 4'h0 && !wr_ctl_l) |=> status[BIT_SST] == 1'b0
		&& status[BIT_TXEF] == 1'b0 && status[BIT_RXFF] == 1'b0)
		else $error("flag set in through mode");
	chk_tx_done_clr: assert property ( // R04
		(CE && unit_en && TX_DONE && !set_vec[BIT_SST]) |=> !status[BIT_SST])
		else $error("tx completion did not clear tx status");
	chk_rx_not_lin: assert property ( // R06
		(CE && lin_m && !status[BIT_SSR] && !status[BIT_ROVE]) |=>
		!status[BIT_SSR] && !status[BIT_ROVE])
		else $error("rx flag set in lin master mode");
	chk_ovf_discard: assert property ( // R09
		(CE && unit_en && uart && rx_ovf) |=> $stable(rx_data_reg) && status[BIT_ROVE])
		else $error("overflow byte stored or flag missing");
	chk_sched_event: assert property ( // R12
		s_sched_hit |=> s_sched_seen)
		else $error("scheduler hit without flag and request");
	chk_disable_reset: assert property ( // R16
		(CE && !unit_en) |=> status == STAT_HIGH_RST)
		else $error("disabled unit kept status");
	chk_set_wins: assert property ( // R18
		(CE && unit_en && set_vec[BIT_TXEF] && clr_vec[BIT_TXEF]) |=> status[BIT_TXEF])
		else $error("clear beat a coincident set");
	chk_w1c_clear: assert property ( // R08
		(CE && unit_en && clr_vec[BIT_RXFF] && !set_vec[BIT_RXFF]) |=> !status[BIT_RXFF])
		else $error("write one did not clear rx full");
	chk_reset_value: assert property ( // R14
		$rose(RST_N) |-> status == STAT_HIGH_RST)
		else $error("status not zero after reset");
endmodule

// *** logic/ltsf_pkg.sv ***
// Purpose: constants for the tx/rx status flag bank
// Assumes: 32-bit AXI4-Lite, 16-bit registers in the low half of a word
// Notes:   status bits 15:6 are flags, 5:0 the master state code
package ltsf_pkg;
	localparam int ADDR_W = 8;
	// register byte offsets
	localparam logic [7:0] OFF_CTL_LOW   = 8'h80;
	localparam logic [7:0] OFF_CTL_HIGH  = 8'h84;
	localparam logic [7:0] OFF_STAT_HIGH = 8'h8C;
	localparam logic [7:0] OFF_STAT_CLR  = 8'h94;
	localparam logic [7:0] OFF_REQ       = 8'h98;
	localparam logic [7:0] OFF_CMP       = 8'hA0;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'hA4;
	localparam logic [7:0] OFF_RX_DATA   = 8'hA8;
	// status high field positions
	localparam int BIT_SST  = 15;
	localparam int BIT_SSR  = 14;
	localparam int BIT_TXEF = 13;
	localparam int BIT_RXFF = 12;
	localparam int BIT_ROVE = 11;
	localparam int BIT_FCSE = 10;
	localparam int BIT_SRF  = 9;
	localparam int BIT_PIE  = 8;
	localparam int BIT_BFE  = 7;
	localparam int BIT_SFE  = 6;
	localparam int FLAG_LSB = 6;
	localparam int FLAG_W   = 10;
	localparam int SSL_W    = 6;
	// control fields
	localparam int BIT_PW   = 15;
	localparam int MODE_LSB = 0;
	localparam int BIT_AFE  = 4;
	localparam int BIT_ACSE = 5;
	localparam int BIT_SCHE = 6;
	localparam int BIT_TRQ  = 0;
	localparam int BIT_RRQ  = 1;
	// reset values
	localparam logic [15:0] STAT_HIGH_RST = 16'h0000;
	localparam logic [15:0] CTL_RST       = 16'h0000;
	localparam logic [15:0] CMP_RST       = 16'h0000;
	localparam logic [15:0] MASK_RST      = 16'h0000;
	// software-clearable flags: 13 down to 6
	localparam logic [15:0] SW_CLR_MASK   = 16'h3FC0;
	// modes
	localparam logic [1:0] MODE_LIN_MASTER = 2'h0;
	localparam logic [1:0] MODE_UART       = 2'h1;
	localparam logic [1:0] MODE_UART_THRU  = 2'h2;
	// master state codes
	localparam logic [5:0] SSL_IDLE    = 6'h00;
	localparam logic [5:0] SSL_NO_RESP = 6'h19;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** logic/ltsf_flags.sv ***
// Purpose: bank of sticky flags with hardware set and clear inputs
// Assumes: set and clear come from logic on the same clock
// Notes:   a disabled unit holds every flag at zero
`timescale 1ns/100ps
module ltsf_flags
	import ltsf_pkg::*;
#(
	parameter int               W   = FLAG_W,
	parameter logic [W-1:0]     RST = '0
)(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         en,
	input  wire logic [W-1:0] set_in,
	input  wire logic [W-1:0] clr_in,
	output logic      [W-1:0] q
);
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	// set is or-ed after the clear so a coincident event is kept
	assign q_next = en ? ((q_reg & ~clr_in) | set_in) : RST;
	assign q      = q_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q_reg <= RST;
		end else if (ce) begin
			q_reg <= q_next;
		end
	end
endmodule

// *** logic/ltsf_csum.sv ***
// Purpose: running checksum over received bytes and compare
// Assumes: start pulses before the first byte of each frame
// Notes:   carry wraps back into bit 0, result is the inverted sum
`timescale 1ns/100ps
module ltsf_csum (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       en,
	input  wire logic       start,
	input  wire logic       byte_valid,
	input  wire logic [7:0] byte_in,
	input  wire logic       chk_valid,
	input  wire logic [7:0] chk_in,
	output logic            err
);
	logic [7:0] sum_reg;
	logic [7:0] sum_next;
	logic [8:0] sum_wide;

	assign sum_wide = {1'b0, sum_reg} + {1'b0, byte_in};
	assign sum_next = sum_wide[7:0] + {7'h00, sum_wide[8]};
	assign err      = chk_valid && (chk_in != ~sum_reg);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sum_reg <= 8'h00;
		end else if (ce) begin
			if (!en || start) begin
				sum_reg <= 8'h00;
			end else if (byte_valid) begin
				sum_reg <= sum_next;
			end
		end
	end
endmodule

// *** sim/ltsf_status_top_test.sv ***
// Purpose: self-checking bench for the tx/rx status flag bank
// Assumes: engine inputs other than the master state are driven as one-cycle pulses on REF_CLK
// Notes:   handshakes are sampled at the falling edge, where they are settled
`timescale 1ns/100ps
module ltsf_status_top_test
	import ltsf_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic        ce      = 1'b1;
	logic [7:0]  awaddr  = 8'h00;
	logic [7:0]  araddr  = 8'h00;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic [31:0] wdata   = 32'h0000_0000;
	logic [3:0]  wstrb   = 4'h0;
	logic [5:0]  ev      = 6'h00;
	logic        rxv     = 1'b0;
	logic        chkv    = 1'b0;
	logic [7:0]  rxb     = 8'h00;
	logic [7:0]  chkb    = 8'h00;
	logic [2:0]  ferr    = 3'h0;
	logic [5:0]  mstate  = 6'h00;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire         unit_en, tx_req, rx_req, sint, irq;
	int          n_errors        = 0;
	int          samples_checked = 0;
	int          cyc             = 0;
	int          hits            = 0;
	int          n_txq           = 0;
	int          n_rxq           = 0;
	logic        cnt_en          = 1'b0;
	int          seed;
	logic [1:0]  r;
	logic [31:0] d;
	logic [7:0]  b0, b1;
	logic [5:0]  v;

	ltsf_status_top i_dut (
		.REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.TX_LAST_SENT(ev[5]), .TX_DONE(ev[4]), .AUTO_FRAME_START(ev[3]),
		.RX_LAST_STORED(ev[2]), .RX_DONE(ev[1]), .RX_FRAME_START(ev[0]),
		.RX_BYTE_VALID(rxv), .RX_BYTE(rxb), .RX_CHK_VALID(chkv), .RX_CHK_BYTE(chkb),
		.FRAME_ERR_SET(ferr), .MASTER_STATE(mstate), .UNIT_ENABLE(unit_en),
		.TX_REQ(tx_req), .RX_REQ(rx_req), .STATUS_INT_REQ(sint), .IRQ(irq)
	);

	always #12.5 ref_clk = ~ref_clk;

	// a hang ends the run through the same report
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end

	always @(negedge ref_clk) begin
		if (cnt_en && sint === 1'b1) hits++;
		if (tx_req === 1'b1) n_txq++;
		if (rx_req === 1'b1) n_rxq++;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// valid and payload held until the edge where ready was seen high
	task automatic wr(input logic [7:0] a, input logic [15:0] dv, output logic [1:0] rs);
		logic aw_t, w_t, b_t;
		b_t = 1'b0;
		rs = 2'h3;
		@(posedge ref_clk);
		awaddr <= a; awvalid <= 1'b1; wdata <= {16'h0000, dv};
		wstrb <= 4'h3; wvalid <= 1'b1; bready <= 1'b1;
		// only the bench timeout ends a wait for the answer
		while (!b_t) begin
			@(negedge ref_clk);
			aw_t = awvalid && (awready === 1'b1);
			w_t = wvalid && (wready === 1'b1);
			b_t = (bvalid === 1'b1);
			rs = bresp;
			@(posedge ref_clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t) bready <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
		logic ar_t, r_t;
		r_t = 1'b0;
		@(posedge ref_clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (!r_t) begin
			@(negedge ref_clk);
			ar_t = arvalid && (arready === 1'b1);
			r_t = (rvalid === 1'b1);
			dv = rdata;
			rs = rresp;
			@(posedge ref_clk);
			if (ar_t) arvalid <= 1'b0;
			if (r_t) rready <= 1'b0;
		end
	endtask

	task automatic stat(input logic [15:0] e);
		logic [31:0] sv;
		logic [1:0]  rs;
		rd(OFF_STAT_HIGH, sv, rs);
		check(sv, {16'h0000, e});
	endtask

	task automatic pulse(input logic [5:0] m);
		@(posedge ref_clk) ev <= m;
		@(posedge ref_clk) ev <= 6'h00;
	endtask

	task automatic send_byte(input logic [7:0] b);
		@(posedge ref_clk) begin
			rxv <= 1'b1;
			rxb <= b;
		end
		@(posedge ref_clk) rxv <= 1'b0;
	endtask

	// carry folds back into bit 0; the frame byte is the inverted sum
	function automatic logic [7:0] cs_add(input logic [7:0] s, input logic [7:0] b);
		logic [8:0] t;
		t = {1'b0, s} + {1'b0, b};
		return t[7:0] + {7'h00, t[8]};
	endfunction

	task automatic frame(input int nb, input logic bad);
		logic [7:0] s, b;
		s = 8'h00;
		pulse(6'h01);
		for (int i = 0; i < nb; i++) begin
			b = 8'($random(seed));
			s = cs_add(s, b);
			send_byte(b);
		end
		@(posedge ref_clk) begin
			chkv <= 1'b1;
			chkb <= ~s ^ {7'h00, bad};
		end
		@(posedge ref_clk) chkv <= 1'b0;
	endtask

	task automatic window(input int exp_hits);
		hits = 0;
		@(posedge ref_clk) cnt_en = 1'b1;
		repeat (60) @(posedge ref_clk);
		cnt_en = 1'b0;
		check(32'(hits), 32'(exp_hits));
	endtask

	initial begin
		seed = 24831;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		stat(STAT_HIGH_RST);
		wr(8'hFC, 16'h1234, r); check({30'h0, r}, {30'h0, RESP_SLVERR});
		rd(8'hFC, d, r); check({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(OFF_CTL_HIGH, 16'h8000, r); check({31'h0, unit_en}, 32'h0000_0001);
		wr(OFF_STAT_HIGH, 16'hFFFF, r); check({30'h0, r}, {30'h0, RESP_OKAY});
		stat(16'h0000);
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? SSL_IDLE : (i == 1) ? SSL_NO_RESP : 6'($random(seed));
			@(posedge ref_clk) mstate <= v;
			stat({10'h000, v});
		end
		@(posedge ref_clk) mstate <= 6'h00;
		wr(OFF_CTL_LOW, 16'h0000, r);
		wr(OFF_REQ, 16'h0001, r); stat(16'h8000);
		pulse(6'h10); stat(16'h0000);
		wr(OFF_REQ, 16'h0002, r); stat(16'h0000);
		v = {3'h0, 3'($random(seed)) | 3'h1};
		@(posedge ref_clk) ferr <= v[2:0];
		@(posedge ref_clk) ferr <= 3'h0;
		stat({7'h00, v[2:0], 6'h00});
		wr(OFF_STAT_CLR, 16'h01C0, r); stat(16'h0000);
		wr(OFF_CTL_LOW, 16'h0010, r);
		pulse(6'h08); stat(16'h8000);
		pulse(6'h10); stat(16'h0000);
		// through mode: requests, buffer events and a double byte set no status flag
		wr(OFF_CTL_LOW, 16'h0002, r);
		wr(OFF_REQ, 16'h0003, r);
		pulse(6'h24);
		send_byte(8'h5A);
		send_byte(8'hA5);
		stat(16'h0000);
		wr(OFF_CTL_LOW, 16'h0001, r);
		rd(OFF_RX_DATA, d, r);
		wr(OFF_REQ, 16'h0002, r); stat(16'h4000);
		pulse(6'h02); stat(16'h0000);
		pulse(6'h24); stat(16'h3000);
		wr(OFF_STAT_CLR, 16'h2000, r); stat(16'h1000);
		wr(OFF_STAT_CLR, 16'h1000, r); stat(16'h0000);
		b0 = 8'($random(seed));
		b1 = ~b0;
		send_byte(b0);
		send_byte(b1);
		stat(16'h0800);
		rd(OFF_RX_DATA, d, r); check({24'h0, d[7:0]}, {24'h0, b0});
		wr(OFF_STAT_CLR, 16'h0800, r); stat(16'h0000);
		// set lands on the very edge that applies the clear
		fork
			wr(OFF_STAT_CLR, 16'h2000, r);
			begin
				@(negedge ref_clk iff (awvalid && awready === 1'b1));
				@(posedge ref_clk) ev <= 6'h20;
				@(posedge ref_clk) ev <= 6'h00;
			end
		join
		stat(16'h2000);
		wr(OFF_STAT_CLR, 16'h2000, r);
		wr(OFF_CTL_LOW, 16'h0020, r);
		frame(8, 1'b0); stat(16'h0000);
		frame(5, 1'b1); stat(16'h0400);
		wr(OFF_STAT_CLR, 16'h0400, r); stat(16'h0000);
		wr(OFF_CTL_LOW, 16'h0000, r);
		frame(3, 1'b1); stat(16'h0000);
		wr(OFF_CMP, 16'h0005, r);
		wr(OFF_IRQ_MASK, 16'h0200, r);
		wr(OFF_CTL_LOW, 16'h0040, r);
		repeat (20) @(posedge ref_clk);
		window(10);
		@(negedge ref_clk) check({31'h0, irq}, 32'h0000_0001);
		wr(OFF_IRQ_MASK, 16'h0000, r);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk) check({31'h0, irq}, 32'h0000_0000);
		wr(OFF_IRQ_MASK, 16'h0200, r);
		wr(OFF_CTL_LOW, 16'h0050, r);
		wr(OFF_STAT_CLR, 16'h0200, r);
		repeat (20) @(posedge ref_clk);
		window(0);
		stat(16'h0000);
		@(negedge ref_clk) check({31'h0, irq}, 32'h0000_0000);
		// disable wipes every flag and the state copy
		wr(OFF_CTL_LOW, 16'h0001, r);
		wr(OFF_REQ, 16'h0003, r);
		pulse(6'h24);
		@(posedge ref_clk) mstate <= SSL_NO_RESP;
		stat({16'hF000 | {10'h000, SSL_NO_RESP}});
		wr(OFF_CTL_HIGH, 16'h0000, r); stat(16'h0000);
		check({31'h0, unit_en}, 32'h0000_0000);
		wr(OFF_REQ, 16'h0001, r);
		pulse(6'h24); stat(16'h0000);
		@(posedge ref_clk) mstate <= SSL_IDLE;
		wr(OFF_CTL_HIGH, 16'h8000, r); stat(16'h0000);
		// request pulses: three tx and four rx writes while enabled
		check(32'(n_txq), 32'h0000_0003);
		check(32'(n_rxq), 32'h0000_0004);
		summarize();
	end
endmodule
